/* ivp_cfg.svh */
// constants for the interrupt vector priority block
`ifndef IVP_CFG_SVH
`define IVP_CFG_SVH
`define IVP_NUM_SRC      17
`define IVP_VEC_RTC      16'hFFDA
`define IVP_VEC_ADC      16'hFFDC
`define IVP_VEC_KEYPAD   16'hFFDE
`define IVP_VEC_SER_TX   16'hFFE0
`define IVP_VEC_SER_RX   16'hFFE2
`define IVP_VEC_SER_ERR  16'hFFE4
`define IVP_VEC_SPI_RX   16'hFFE6
`define IVP_VEC_SPI_TX   16'hFFE8
`define IVP_VEC_T2_OVF   16'hFFEA
`define IVP_VEC_T2_CH1   16'hFFEC
`define IVP_VEC_T2_CH0   16'hFFEE
`define IVP_VEC_T1_OVF   16'hFFF0
`define IVP_VEC_T1_CH1   16'hFFF2
`define IVP_VEC_T1_CH0   16'hFFF4
`define IVP_VEC_PLL      16'hFFF6
`define IVP_VEC_LVI      16'hFFF8
`define IVP_VEC_EXT_IRQ  16'hFFFA
`define IVP_VEC_SWI      16'hFFFC
`define IVP_VEC_RESET    16'hFFFE
`define IVP_SP_RESET     16'h00FF
`define IVP_STACK_BYTES  3'h5
`define IVP_LAST_BYTE    3'h4
`define IVP_VEC_LOW_BIT  16'h0001
`endif

/* ivp_pkg.sv */
// types shared by the interrupt vector priority block
package ivp_pkg;
  typedef enum logic [1:0] {
    IVP_IDLE  = 2'b00,
    IVP_STACK = 2'b01,
    IVP_VEC_H = 2'b10,
    IVP_VEC_L = 2'b11
  } ivp_state_t;

  typedef struct packed {
    logic        req;
    logic        software_interrupt_opcode;
    logic [16:0] pend;
  } ivp_sel_in_t;
endpackage

/* ivp_sel_if.sv */
// request carrier between sequencer and priority selector
`timescale 1ns/1ps
interface ivp_sel_if;
  import ivp_pkg::*;
  logic [16:0] pend;
  logic        software_interrupt_opcode;
  logic        any;
  logic [15:0] vec;
  modport seq (output pend, output software_interrupt_opcode, input any, input vec);
  modport sel (input pend, input software_interrupt_opcode, output any, output vec);
endinterface

/* ivp_prio_sel.sv */
// fixed priority selector: pending sources to vector address
`timescale 1ns/1ps
`include "ivp_cfg.svh"
module ivp_prio_sel
  import ivp_pkg::*;
(
  ivp_sel_if.sel s
);
  // bit 0 external irq ... bit 16 rtc; lower index ranks higher
  function automatic logic [15:0] pick(input logic [16:0] p, input logic software_interrupt_opcode);
    logic [15:0] v;
    v = `IVP_VEC_RTC;
    if (software_interrupt_opcode)         v = `IVP_VEC_SWI;     // [R13]
    else if (p[0])   v = `IVP_VEC_EXT_IRQ; // [R13]
    else if (p[1])   v = `IVP_VEC_LVI;     // [R13]
    else if (p[2])   v = `IVP_VEC_PLL;     // [R13]
    else if (p[3])   v = `IVP_VEC_T1_CH0;  // [R13]
    else if (p[4])   v = `IVP_VEC_T1_CH1;  // [R12]
    else if (p[5])   v = `IVP_VEC_T1_OVF;  // [R11]
    else if (p[6])   v = `IVP_VEC_T2_CH0;  // [R10]
    else if (p[7])   v = `IVP_VEC_T2_CH1;  // [R9]
    else if (p[8])   v = `IVP_VEC_T2_OVF;  // [R8]
    else if (p[9])   v = `IVP_VEC_SPI_TX;  // [R7]
    else if (p[10])  v = `IVP_VEC_SPI_RX;  // [R6]
    else if (p[11])  v = `IVP_VEC_SER_ERR; // [R5]
    else if (p[12])  v = `IVP_VEC_SER_RX;  // [R4]
    else if (p[13])  v = `IVP_VEC_SER_TX;  // [R3]
    else if (p[14])  v = `IVP_VEC_KEYPAD;  // [R3]
    else if (p[15])  v = `IVP_VEC_ADC;     // [R2]
    else             v = `IVP_VEC_RTC;     // [R1]
    return v;
  endfunction

  // highest ranked pending source wins
  assign s.vec = pick(s.pend, s.software_interrupt_opcode); // [R18]
  assign s.any = s.software_interrupt_opcode | (|s.pend);
endmodule

/* ivp_top.sv */
// interrupt vector selection and stacking sequencer
// What this block does
// R1 - rtc_flag ranks lowest; vector at FFDA high, FFDB low.
// R2 - adc_done_flag ranks above rtc; vector at FFDC.
// R3 - serial_tx_flag at FFE0 ranks above keypad_flag at FFDE.
// R4 - serial_rx_flag at FFE2, just above serial transmit.
// R5 - serial_err_flag at FFE4, just above serial receive.
// R6 - spi_rx_flag at FFE6, just above serial error.
// R7 - spi_tx_flag at FFE8, just above spi receive.
// R8 - timer_two_ovf_flag at FFEA, just above spi transmit.
// R9 - timer_two_ch1_flag at FFEC, just above timer two overflow.
// R10 - timer_two_ch0_flag at FFEE, just above timer two channel 1.
// R11 - timer_one_ovf_flag at FFF0, just above timer two channel 0.
// R12 - timer_one_ch1_flag at FFF2, just above timer one overflow.
// R13 - ch0 FFF4, then pll, low voltage, external irq, software, reset highest.
// R14 - interrupt entry pushes five register bytes before vector fetch.
// R15 - upper index register is never stacked.
// R16 - reset loads 16-bit stack pointer with 00FF.
// R17 - each push decrements the stack pointer; a pull increments it only when idle, with no sp_load or in_reset_fetch in the same cycle.
// R18 - simultaneous pending sources yield the highest ranked vector.
`timescale 1ns/1ps
`include "ivp_cfg.svh"
module ivp_top
  import ivp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [16:0] src_flag,
  input  wire logic [16:0] src_enable,
  input  wire logic        global_mask,
  input  wire logic        swi_req,
  input  wire logic        in_reset_fetch,
  input  wire logic        sp_load,
  input  wire logic [15:0] sp_load_value,
  input  wire logic        pull_byte,
  input  wire logic        step,
  output logic             int_active,
  output logic             push_strobe,
  output logic [15:0]      push_addr,
  output logic [2:0]       push_index,
  output logic             fetch_strobe,
  output logic [15:0]      fetch_addr,
  output logic [15:0]      stack_ptr,
  output logic [15:0]      taken_vector
);

  typedef struct packed {
    ivp_state_t  st;
    logic [2:0]  cnt;
    logic [15:0] sp;
    logic [15:0] vec;
    logic        push;
    logic [15:0] paddr;
    logic        fetch;
    logic [15:0] faddr;
    logic        active;
  } ivp_regs_t;

  ivp_regs_t r;
  ivp_regs_t next_r;

  ivp_sel_if sel_bus ();

  // only enabled flags compete; the global mask blocks maskable ones
  assign sel_bus.pend = src_flag & src_enable & {`IVP_NUM_SRC{~global_mask}};
  assign sel_bus.software_interrupt_opcode  = swi_req;

  ivp_prio_sel u_sel (
    .s (sel_bus)
  );

  // sequencer: stack five bytes, then fetch vector high and low
  always_comb begin
    next_r       = r;
    next_r.push  = 1'b0;
    next_r.fetch = 1'b0;
    if (in_reset_fetch) begin
      // reset vector outranks all, no stacking
      next_r.vec    = `IVP_VEC_RESET; // [R13]
      next_r.st     = IVP_VEC_H;
      next_r.active = 1'b1;
      next_r.cnt    = 3'h0;
    end else begin
      case (r.st)
        IVP_IDLE: begin
          if (sp_load) begin
            next_r.sp = sp_load_value; // software may move the stack anywhere
          end else if (pull_byte) begin
            next_r.sp = r.sp + 16'h0001; // [R17]
          end
          if (sel_bus.any) begin
            next_r.vec    = sel_bus.vec; // [R18]
            next_r.st     = IVP_STACK;
            next_r.cnt    = 3'h0;
            next_r.active = 1'b1;
          end
        end
        IVP_STACK: begin
          // five bytes: pcl, pch, x, a, ccr; upper index skipped [R15]
          if (step) begin
            next_r.push  = 1'b1;
            next_r.paddr = r.sp;
            next_r.sp    = r.sp - 16'h0001; // [R17]
            next_r.cnt   = r.cnt + 3'h1;
            if (r.cnt == `IVP_LAST_BYTE) begin
              next_r.st = IVP_VEC_H; // [R14]
            end
          end
        end
        IVP_VEC_H: begin
          if (step) begin
            next_r.fetch = 1'b1;
            next_r.faddr = r.vec;
            next_r.st    = IVP_VEC_L;
          end
        end
        IVP_VEC_L: begin
          if (step) begin
            next_r.fetch  = 1'b1;
            next_r.faddr  = r.vec | `IVP_VEC_LOW_BIT; // [R1]
            next_r.st     = IVP_IDLE;
            next_r.active = 1'b0;
          end
        end
        default: begin
          next_r.st = IVP_IDLE;
        end
      endcase
    end
  end

  // state register; stack pointer restarts at its reset location
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r        <= '0;
      r.st     <= IVP_IDLE;
      r.sp     <= `IVP_SP_RESET; // [R16]
    end else begin
      r <= next_r;
    end
  end

  assign int_active   = r.active;
  assign push_strobe  = r.push;
  assign push_addr    = r.paddr;
  assign push_index   = r.cnt;
  assign fetch_strobe = r.fetch;
  assign fetch_addr   = r.faddr;
  assign stack_ptr    = r.sp;
  assign taken_vector = r.vec;
endmodule

/* ivp_top_asserts.sv */
// property checker for the vector priority block
`timescale 1ns/1ps
module ivp_top_asserts
  import ivp_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [16:0] src_flag,
  input wire logic [16:0] src_enable,
  input wire logic        global_mask,
  input wire logic        swi_req,
  input wire logic        in_reset_fetch,
  input wire logic        sp_load,
  input wire logic [15:0] sp_load_value,
  input wire logic        pull_byte,
  input wire logic        step,
  input wire logic        int_active,
  input wire logic        push_strobe,
  input wire logic [15:0] push_addr,
  input wire logic [2:0]  push_index,
  input wire logic        fetch_strobe,
  input wire logic [15:0] fetch_addr,
  input wire logic [15:0] stack_ptr,
  input wire logic [15:0] taken_vector
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // entry must reach the vector fetch even with a slow core
  sequence s_entry; $rose(int_active); endsequence
  sequence s_fetch; ##[1:40] fetch_strobe; endsequence
  property p_entry; s_entry |-> s_fetch; endproperty
  a_entry: assert property (p_entry) else $error("no fetch after entry");
  property p_five; fetch_strobe && !fetch_addr[0] && fetch_addr != 16'hFFFE |-> push_index == 3'h5; endproperty
  a_five: assert property (p_five) else $error("stack frame not five bytes");
  property p_dec; push_strobe |-> stack_ptr == push_addr - 16'h0001; endproperty
  a_dec: assert property (p_dec) else $error("push did not decrement");
  // a reset fetch outranks a pull in the same cycle
  property p_pull;
    pull_byte && !int_active && !sp_load && !in_reset_fetch |=>
      stack_ptr == $past(stack_ptr) + 16'h0001;
  endproperty
  a_pull: assert property (p_pull) else $error("pull did not increment");
  property p_rst; $rose(nrst) |-> stack_ptr == 16'h00FF; endproperty
  a_rst: assert property (p_rst) else $error("stack pointer reset value");
  property p_vec; fetch_strobe |-> fetch_addr[15:1] == taken_vector[15:1]; endproperty
  a_vec: assert property (p_vec) else $error("fetch off taken vector");
  property p_range; int_active |-> taken_vector >= 16'hFFDA && !taken_vector[0]; endproperty
  a_range: assert property (p_range) else $error("vector outside table");
  property p_mask; !int_active && global_mask && !swi_req && !in_reset_fetch |=> !int_active; endproperty
  a_mask: assert property (p_mask) else $error("masked source accepted");
endmodule
bind ivp_top ivp_top_asserts chk_u (.*);

/* ivp_core_model.sv */
// core-side model pacing the entry sequence
`timescale 1ns/1ps
module ivp_core_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic slow,
  output logic      step
);
  // slow mode drops step every other cycle, stalling each byte, so held outputs get exercised
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      step <= 1'b0;
    else
      step <= slow ? !step : 1'b1;
  end
endmodule

/* ivp_top_tb.sv */
// self-checking bench for the vector priority block
`timescale 1ns/1ps
module ivp_top_tb;
  logic        clk = 1'b0, nrst = 1'b0, mask = 1'b0, software_interrupt_opcode = 1'b0, rf = 1'b0;
  logic        ld = 1'b0, pull = 1'b0, slow = 1'b0, step;
  logic [16:0] flag = 17'h00000, en = 17'h1FFFF;
  logic [15:0] ldv = 16'h0000, sp_exp;
  logic        act, ps, fs;
  logic [2:0]  pi;
  logic [15:0] pa, fa, sp, tv;
  int          error_cnt, cmp_count, cyc;
  ivp_top dut_u (.clk(clk), .nrst(nrst), .src_flag(flag), .src_enable(en), .global_mask(mask),
    .swi_req(software_interrupt_opcode), .in_reset_fetch(rf), .sp_load(ld), .sp_load_value(ldv), .pull_byte(pull),
    .step(step), .int_active(act), .push_strobe(ps), .push_addr(pa), .push_index(pi),
    .fetch_strobe(fs), .fetch_addr(fa), .stack_ptr(sp), .taken_vector(tv));
  ivp_core_model core_u (.clk(clk), .nrst(nrst), .slow(slow), .step(step));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    forever #4 clk = !clk;
  end
  // hang guard, far above the whole sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // one entry: raise request, follow pushes, check both fetches
  task automatic run_int(input logic [16:0] f, input logic s, input logic r,
    input logic [15:0] v, input int n);
    int np;
    int nf;
    np = 0;
    nf = 0;
    @(posedge clk);
    sp_exp = sp;
    flag <= f;
    software_interrupt_opcode <= s;
    rf <= r;
    for (int i = 0; i < 60 && nf < 2; i++) begin
      @(posedge clk);
      if (act === 1'b1) begin
        flag <= 17'h00000;
        software_interrupt_opcode <= 1'b0;
        rf <= 1'b0;
      end
      #1;
      if (ps === 1'b1) begin
        chk(pa, sp_exp);
        chk(16'(pi), 16'(np + 1));
        sp_exp = sp_exp - 16'h0001;
        np++;
      end
      if (fs === 1'b1) begin
        chk(fa, v | 16'(nf));
        nf++;
      end
    end
    chk(16'(np), 16'(n));
    chk(tv, v);
    chk(sp, sp_exp);
    @(posedge clk);
  endtask
  // moved stack pointer, then a pull
  task automatic t_sp();
    @(posedge clk);
    ld <= 1'b1;
    ldv <= 16'h0200;
    @(posedge clk);
    ld <= 1'b0;
    pull <= 1'b1;
    @(posedge clk);
    pull <= 1'b0;
    #1;
    chk(sp, 16'h0201);
  endtask
  // disabled or masked sources must not start an entry
  task automatic t_mask();
    @(posedge clk);
    mask <= 1'b1;
    flag <= 17'h1FFFF;
    repeat (4) @(posedge clk);
    mask <= 1'b0;
    en <= 17'h00000;
    #1;
    chk(act, 1'b0);
    repeat (4) @(posedge clk);
    flag <= 17'h00000;
    en <= 17'h1FFFF;
    #1;
    chk(act, 1'b0);
  endtask
  // mid-run reset must bring a moved stack pointer home
  task automatic t_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    chk(sp, 16'h00FF);
    chk(act, 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    chk(sp, 16'h00FF);
    chk(act, 1'b0);
    t_sp();
    t_mask();
    // each pass leaves only source b and lower ranks pending
    for (int b = 16; b >= 0; b--) begin
      slow <= b[0];
      run_int(17'h1FFFF << b, 1'b0, 1'b0, 16'hFFFA - 16'(2 * b), 5);
    end
    run_int(17'h1FFFF, 1'b1, 1'b0, 16'hFFFC, 5);
    run_int(17'h1FFFF, 1'b1, 1'b1, 16'hFFFE, 0);
    t_reset();
    // first entry after the mid-run reset pushes from the reset location
    run_int(17'h00008, 1'b0, 1'b0, 16'hFFF4, 5);
    give_verdict();
  end
endmodule
